// File: stfc_scan_trigger_feedback_ctrl.v
// Scan trigger, reset detect, good-read LED and beeper controller with APB registers
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "stfc_defs.vh"

module stfc_scan_trigger_feedback_ctrl #(
    parameter RESET_MIN_CYC = `STFC_RESET_MIN_MS * `STFC_MS_CYCLES,
    parameter PON_DELAY_CYC = `STFC_PON_DELAY_MS * `STFC_MS_CYCLES,
    parameter PON_STEP_CYC  = `STFC_PON_STEP_MS * `STFC_MS_CYCLES,
    parameter MS_CYC        = `STFC_MS_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        scan_trigger_n,
    input  wire        engine_reset_n,
    input  wire        decode_done,
    output wire        decode_active,
    output reg         engine_reset_req,
    output reg         good_read_indicator,
    output reg         beeper_out
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg  [31:0] ctrl_reg;
    reg  [31:0] sessTo_reg;
    reg  [15:0] ledMs_reg;
    reg  [15:0] toneMs_reg;
    reg  [15:0] toneHp_reg;
    reg         session_reg;
    reg         trigPrev_reg;
    reg  [31:0] sessCnt_reg;
    reg  [31:0] msCnt_reg;
    reg         msTick_reg;
    reg  [31:0] rstCnt_reg;
    reg  [31:0] ponCnt_reg;
    reg  [1:0]  ponPhase;
    reg         ponDone_reg;
    reg  [1:0]  beepMode_reg;
    reg  [15:0] ledLeft_reg;
    reg  [15:0] toneLeft_reg;
    reg  [15:0] halfCnt_reg;
    reg         pwm_reg;
    reg  [15:0] halfPer;

    localparam MODE_IDLE = 2'd0;
    localparam MODE_PON  = 2'd1;
    localparam MODE_GR   = 2'd2;

    // Reset values and tone half periods, cut to register width on purpose
    localparam [31:0] LED_MS_W  = `STFC_GR_LED_MS;
    localparam [31:0] TONE_MS_W = `STFC_GR_TONE_MS;
    localparam [31:0] TONE_HP_W = `STFC_HALF_PER(`STFC_GR_TONE_HZ);
    localparam [31:0] PON_HP0_W = `STFC_HALF_PER(`STFC_PON_HZ0);
    localparam [31:0] PON_HP1_W = `STFC_HALF_PER(`STFC_PON_HZ1);
    localparam [31:0] PON_HP2_W = `STFC_HALF_PER(`STFC_PON_HZ2);
    localparam [31:0] PON_HP3_W = `STFC_HALF_PER(`STFC_PON_HZ3);

    wire        wrEn      = psel & penable & pwrite;
    wire        pulseMode = ctrl_reg[`STFC_CTRL_PULSE];
    wire        trigLow   = ~scan_trigger_n;
    wire        trigFall  = trigLow & ~trigPrev_reg;
    wire        goodRead  = session_reg & decode_done;

    assign pready        = 1'b1;
    assign pslverr       = 1'b0;
    assign decode_active = session_reg;

    // Register writes
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg   <= `STFC_CTRL_RESET;
            sessTo_reg <= `STFC_SESS_TO_MS;
            ledMs_reg  <= LED_MS_W[15:0];
            toneMs_reg <= TONE_MS_W[15:0];
            toneHp_reg <= TONE_HP_W[15:0];
        end else if (wrEn) begin
            case (paddr)
                `STFC_REG_CTRL:    ctrl_reg   <= {28'h0000000, pwdata[3:0]};
                `STFC_REG_SESS_TO: sessTo_reg <= pwdata;
                `STFC_REG_LED_MS:  ledMs_reg  <= pwdata[15:0];
                `STFC_REG_TONE_MS: toneMs_reg <= pwdata[15:0];
                `STFC_REG_TONE_HP: toneHp_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Read mux, unmapped reads give zero
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `STFC_REG_CTRL:    prdata <= ctrl_reg;
                `STFC_REG_SESS_TO: prdata <= sessTo_reg;
                `STFC_REG_LED_MS:  prdata <= {16'h0000, ledMs_reg};
                `STFC_REG_TONE_MS: prdata <= {16'h0000, toneMs_reg};
                `STFC_REG_TONE_HP: prdata <= {16'h0000, toneHp_reg};
                `STFC_REG_STATUS:  prdata <= {27'h0000000, engine_reset_req, ponDone_reg,
                                              beeper_out, good_read_indicator, session_reg};
                default:           prdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            msCnt_reg  <= 32'h00000000;
            msTick_reg <= 1'b0;
        end else if (msCnt_reg == MS_CYC - 1) begin
            msCnt_reg  <= 32'h00000000;
            msTick_reg <= 1'b1;
        end else begin
            msCnt_reg  <= msCnt_reg + 32'h00000001;
            msTick_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Decode session control
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            session_reg  <= 1'b0;
            trigPrev_reg <= 1'b0;
            sessCnt_reg  <= 32'h00000000;
        end else begin
            trigPrev_reg <= trigLow;
            if (session_reg) begin
                if (decode_done) begin
                    session_reg <= 1'b0;
                end else if (!pulseMode && !trigLow) begin
                    session_reg <= 1'b0;
                end else if (pulseMode && msTick_reg) begin
                    if (sessCnt_reg + 32'h00000001 >= sessTo_reg) begin
                        session_reg <= 1'b0;
                    end
                    sessCnt_reg <= sessCnt_reg + 32'h00000001;
                end
            end else if (ponDone_reg || PON_DELAY_CYC == 0) begin
                // Ignore the trigger until boot delay has passed
                if (!pulseMode && trigLow) begin
                    session_reg <= 1'b1;
                end else if (pulseMode && trigFall) begin
                    session_reg <= 1'b1;
                    sessCnt_reg <= 32'h00000000;
                end
            end
        end
    end

    // ****************************************************************
    // Reset input low-time detector
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstCnt_reg       <= 32'h00000000;
            engine_reset_req <= 1'b0;
        end else if (engine_reset_n) begin
            rstCnt_reg       <= 32'h00000000;
            engine_reset_req <= 1'b0;
        end else if (rstCnt_reg < RESET_MIN_CYC) begin
            rstCnt_reg <= rstCnt_reg + 32'h00000001;
        end else begin
            engine_reset_req <= 1'b1;
        end
    end

    // ****************************************************************
    // Power-on sequencing
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ponCnt_reg  <= 32'h00000000;
            ponDone_reg <= 1'b0;
        end else if (!ponDone_reg) begin
            if (ponCnt_reg == PON_DELAY_CYC - 1) begin
                ponDone_reg <= 1'b1;
            end
            ponCnt_reg <= ponCnt_reg + 32'h00000001;
        end else if (beepMode_reg == MODE_PON
                     || (ponCnt_reg == PON_DELAY_CYC && !ctrl_reg[`STFC_CTRL_PON_EN])) begin
            // Step past the start point when muted, so a later enable stays silent
            ponCnt_reg <= ponCnt_reg + 32'h00000001;
        end
    end

    // Power-on tone step, four equal steps after the delay
    always @* begin
        if (ponCnt_reg < PON_DELAY_CYC + PON_STEP_CYC) begin
            ponPhase = 2'd0;
        end else if (ponCnt_reg < PON_DELAY_CYC + 2 * PON_STEP_CYC) begin
            ponPhase = 2'd1;
        end else if (ponCnt_reg < PON_DELAY_CYC + 3 * PON_STEP_CYC) begin
            ponPhase = 2'd2;
        end else begin
            ponPhase = 2'd3;
        end
    end

    // Half period of the current tone
    always @* begin
        halfPer = toneHp_reg;
        if (beepMode_reg == MODE_PON) begin
            case (ponPhase)
                2'd0:    halfPer = PON_HP0_W[15:0];
                2'd1:    halfPer = PON_HP1_W[15:0];
                2'd2:    halfPer = PON_HP2_W[15:0];
                default: halfPer = PON_HP3_W[15:0];
            endcase
        end
    end

    // ****************************************************************
    // Beeper state machine
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            beepMode_reg <= MODE_IDLE;
            toneLeft_reg <= 16'h0000;
        end else begin
            case (beepMode_reg)
                MODE_IDLE: begin
                    if (ponDone_reg && ponCnt_reg == PON_DELAY_CYC
                        && ctrl_reg[`STFC_CTRL_PON_EN]) begin
                        beepMode_reg <= MODE_PON;
                    end else if (goodRead && ctrl_reg[`STFC_CTRL_GR_EN]
                                 && toneMs_reg != 16'h0000) begin
                        beepMode_reg <= MODE_GR;
                        toneLeft_reg <= toneMs_reg;
                    end
                end
                MODE_PON: begin
                    if (ponCnt_reg >= PON_DELAY_CYC + 4 * PON_STEP_CYC - 1) begin
                        beepMode_reg <= MODE_IDLE;
                    end
                end
                MODE_GR: begin
                    if (msTick_reg) begin
                        if (toneLeft_reg == 16'h0001) begin
                            beepMode_reg <= MODE_IDLE;
                        end
                        toneLeft_reg <= toneLeft_reg - 16'h0001;
                    end
                end
                default: beepMode_reg <= MODE_IDLE;
            endcase
        end
    end

    // PWM square wave generator
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            halfCnt_reg <= 16'h0000;
            pwm_reg     <= 1'b0;
            beeper_out  <= 1'b0;
        end else if (beepMode_reg == MODE_IDLE) begin
            halfCnt_reg <= 16'h0000;
            pwm_reg     <= 1'b0;
            beeper_out  <= 1'b0;
        end else begin
            if (halfCnt_reg + 16'h0001 >= halfPer) begin
                halfCnt_reg <= 16'h0000;
                pwm_reg     <= ~pwm_reg;
            end else begin
                halfCnt_reg <= halfCnt_reg + 16'h0001;
            end
            beeper_out <= pwm_reg;
        end
    end

    // ****************************************************************
    // Good-read indicator pulse
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ledLeft_reg         <= 16'h0000;
            good_read_indicator <= 1'b0;
        end else if (goodRead && ctrl_reg[`STFC_CTRL_LED_EN] && ledMs_reg != 16'h0000) begin
            ledLeft_reg         <= ledMs_reg;
            good_read_indicator <= 1'b1;
        end else if (ledLeft_reg == 16'h0000) begin
            good_read_indicator <= 1'b0;
        end else if (msTick_reg) begin
            if (ledLeft_reg == 16'h0001) begin
                good_read_indicator <= 1'b0;
            end
            ledLeft_reg <= ledLeft_reg - 16'h0001;
        end
    end

endmodule // stfc_scan_trigger_feedback_ctrl

// File: stfc_defs.vh
// Constants and register map of the scan trigger and feedback controller
//
// Function
// - The trigger input is read in level or pulse mode, whichever is configured.
// - In level mode a low trigger starts a decode session at once.
// - In level mode the session ends on a good read or trigger release, whichever is first.
// - In pulse mode a short low pulse starts a session that runs until a good read or timeout.
// - The pulse mode session timeout is a programmable duration.
// - A reset input held low longer than 10 ms is taken as a reset request.
// - Each good read drives the indicator high for a programmable time, 20 ms by default.
// - A programmable enable suppresses the indicator pulse when off.
// - From 215 ms after power-on a 400 ms tone steps through 2090, 2630, 3130 and 4260 Hz.
// - Each good read while the beeper is idle plays a tone of 80 ms at 2710 Hz by default.
// - Separate enables suppress the power-on tone and the good-read tone.
`ifndef STFC_DEFS_VH
`define STFC_DEFS_VH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define STFC_CLK_HZ        25000000
`define STFC_MS_CYCLES     (`STFC_CLK_HZ / 1000)

// ****************************************************************
// Timing figures in milliseconds and hertz
// ****************************************************************
`define STFC_RESET_MIN_MS  10
`define STFC_PON_DELAY_MS  215
`define STFC_PON_TONE_MS   400
`define STFC_PON_STEP_MS   (`STFC_PON_TONE_MS / 4)
`define STFC_GR_LED_MS     20
`define STFC_GR_TONE_MS    80
`define STFC_GR_TONE_HZ    2710
`define STFC_PON_HZ0       2090
`define STFC_PON_HZ1       2630
`define STFC_PON_HZ2       3130
`define STFC_PON_HZ3       4260
`define STFC_SESS_TO_MS    3000
`define STFC_HALF_PER(hz)  (`STFC_CLK_HZ / (2 * (hz)))

// ****************************************************************
// APB register map (byte offsets)
// ****************************************************************
`define STFC_REG_CTRL      12'h000
`define STFC_REG_SESS_TO   12'h004
`define STFC_REG_LED_MS    12'h008
`define STFC_REG_TONE_MS   12'h00c
`define STFC_REG_TONE_HP   12'h010
`define STFC_REG_STATUS    12'h014

// Control fields
`define STFC_CTRL_PULSE    0
`define STFC_CTRL_LED_EN   1
`define STFC_CTRL_PON_EN   2
`define STFC_CTRL_GR_EN    3
`define STFC_CTRL_RESET    32'h0000_000e

// Status fields
`define STFC_ST_SESSION    0
`define STFC_ST_LED        1
`define STFC_ST_BEEP       2
`define STFC_ST_PON_DONE   3
`define STFC_ST_RST_REQ    4

`endif

// File: stfc_chk.sv
// Checker of session, reset request and indicator timing
`timescale 1ns/100ps
module stfc_chk #(
    parameter RESET_MIN_CYC = 20, parameter PON_DELAY_CYC = 50
) (
    input logic        sys_clk,
    input logic        rst_b,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        scan_trigger_n,
    input logic        engine_reset_n,
    input logic        decode_done,
    input logic        decode_active,
    input logic        engine_reset_req,
    input logic        good_read_indicator,
    input logic        beeper_out
);
    logic        pulse_reg, ledEn_reg;
    logic [31:0] boot_reg, low_reg;
    wire         ctrlWr = psel && penable && pwrite && paddr == 12'h000;
    wire         booted = boot_reg > PON_DELAY_CYC + 2;
    // Mirror of mode and indicator enable, boot and reset-low counters
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_reg <= 1'b0;
            ledEn_reg <= 1'b1;
            boot_reg  <= 32'h0;
            low_reg   <= 32'h0;
        end else begin
            if (ctrlWr) begin
                pulse_reg <= pwdata[0];
                ledEn_reg <= pwdata[1];
            end
            if (!booted)
                boot_reg <= boot_reg + 32'h1;
            low_reg <= engine_reset_n ? 32'h0 : low_reg + 32'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Port timing relations
    quiet_boot_a: assert property (boot_reg + 2 < PON_DELAY_CYC
        |-> !beeper_out && !good_read_indicator) else $error("output active in boot");
    reset_early_a: assert property ($rose(engine_reset_req)
        |-> low_reg >= RESET_MIN_CYC) else $error("reset flag too early");
    reset_late_a: assert property (low_reg == RESET_MIN_CYC + 4
        |-> engine_reset_req) else $error("reset flag missing");
    level_start_a: assert property (!pulse_reg && booted && !decode_active && !scan_trigger_n
        |=> decode_active) else $error("level trigger ignored");
    level_end_a: assert property (!pulse_reg && decode_active && scan_trigger_n
        |=> !decode_active) else $error("session kept after release");
    done_end_a: assert property (decode_active && decode_done
        |=> !decode_active) else $error("session kept after good read");
    pulse_start_a: assert property (pulse_reg && booted && !decode_active && $fell(scan_trigger_n)
        |=> decode_active) else $error("trigger pulse ignored");
    led_cause_a: assert property ($rose(good_read_indicator)
        |-> $past(decode_active && decode_done && ledEn_reg)) else $error("stray indicator");
endmodule // stfc_chk

bind stfc_scan_trigger_feedback_ctrl stfc_chk #(.RESET_MIN_CYC(RESET_MIN_CYC),
    .PON_DELAY_CYC(PON_DELAY_CYC)) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata),
    .scan_trigger_n(scan_trigger_n), .engine_reset_n(engine_reset_n),
    .decode_done(decode_done), .decode_active(decode_active),
    .engine_reset_req(engine_reset_req), .good_read_indicator(good_read_indicator),
    .beeper_out(beeper_out));

// File: stfc_host_model.sv
// Host model driving the trigger and engine reset lines
`timescale 1ns/100ps
module stfc_host_model (
    input  logic sys_clk,
    output logic scan_trigger_n,
    output logic engine_reset_n
);
    // Lines idle high like the pull-ups, untouched during boot
    initial {scan_trigger_n, engine_reset_n} = 2'b11;
    // Hold the trigger low for a count of cycles
    task automatic press(input int n);
        scan_trigger_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        scan_trigger_n <= 1'b1;
    endtask
    // Hold the reset line low for a count of cycles
    task automatic hold_reset(input int n);
        engine_reset_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        engine_reset_n <= 1'b1;
    endtask
endmodule // stfc_host_model

// File: stfc_scan_trigger_feedback_ctrl_tb_top.sv
// Self-checking bench of the scan trigger and feedback controller
`timescale 1ns/100ps
module stfc_scan_trigger_feedback_ctrl_tb_top;
    logic        sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, decode_done = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, scan_trigger_n, engine_reset_n, decode_active;
    wire         engine_reset_req, good_read_indicator, beeper_out;
    int          bad_count = 0, n_checks = 0, cycCnt = 0;
    int          cnt [5]; // Indicator, toggles, last toggle, session, reset flag
    // Scaled timing: reset low time, boot delay, tone step, cycles per ms
    localparam int RST_CYC = 20, BOOT_CYC = 50, STEP_CYC = 6000, MS_TICK = 10;
    // Register rows: write flag, address, write data, expected read
    logic [76:0] rows [11] = '{{1'b0, 12'h000, 32'h0, 32'he}, {1'b0, 12'h004, 32'h0, 32'hbb8},
        {1'b0, 12'h008, 32'h0, 32'h14}, {1'b0, 12'h00c, 32'h0, 32'h50},
        {1'b0, 12'h010, 32'h0, 32'h1204}, {1'b1, 12'h018, 32'h5, 32'h0},
        {1'b1, 12'h004, 32'h64, 32'h64}, {1'b1, 12'h008, 32'h2, 32'h2},
        {1'b1, 12'h00c, 32'h4, 32'h4}, {1'b1, 12'h010, 32'h3, 32'h3},
        {1'b0, 12'h014, 32'h0, 32'h8}};

    stfc_scan_trigger_feedback_ctrl #(.RESET_MIN_CYC(RST_CYC), .PON_DELAY_CYC(BOOT_CYC),
        .PON_STEP_CYC(STEP_CYC), .MS_CYC(MS_TICK)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_trigger_n(scan_trigger_n), .engine_reset_n(engine_reset_n),
        .decode_done(decode_done), .decode_active(decode_active),
        .engine_reset_req(engine_reset_req), .good_read_indicator(good_read_indicator),
        .beeper_out(beeper_out));
    stfc_host_model host_u (.sys_clk(sys_clk), .scan_trigger_n(scan_trigger_n),
        .engine_reset_n(engine_reset_n));

    // Clock and hang guard
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycCnt++;
        if (cycCnt == 30000) begin
            bad_count++;
            test_done();
        end
    end
    // Range compare of one result
    task automatic chk(input string nm, input logic [31:0] lo, hi, got);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            bad_count++;
            $display("unexpected %s: expected %0d to %0d, seen %0d", nm, lo, hi, got);
        end
    endtask
    // One APB transfer, read data left in rd
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Count output activity over a window of cycles
    task automatic measure(input int win);
        logic prevBeep;
        cnt = '{default: 0};
        prevBeep = beeper_out;
        for (int i = 1; i <= win; i++) begin
            @(negedge sys_clk);
            cnt[0] += (good_read_indicator === 1'b1);
            cnt[3] += (decode_active === 1'b1);
            cnt[4] += (engine_reset_req === 1'b1);
            if (beeper_out !== prevBeep) begin
                cnt[1]++;
                cnt[2] = i;
            end
            prevBeep = beeper_out;
        end
        @(posedge sys_clk);
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        // Power-on tone: six edges over four steps, last one near the end of the tone
        measure(24200);
        chk("power-on toggles", 5, 7, cnt[1]);
        chk("power-on end", 23000, 24100, cnt[2]);
        $display("test power-on done");
        foreach (rows[i]) begin
            if (rows[i][76])
                apb(1'b1, rows[i][75:64], rows[i][63:32]);
            apb(1'b0, rows[i][75:64], 32'h0);
            chk("register", rows[i][31:0], rows[i][31:0], rd);
            chk("bus response", 32'h2, 32'h2, {30'h0, pready, pslverr});
        end
        $display("test registers done");
        // Level mode good read, trigger released on the same edge
        fork host_u.press(6); join_none
        repeat (5) @(posedge sys_clk);
        decode_done <= 1'b1;
        @(posedge sys_clk);
        decode_done <= 1'b0;
        measure(120);
        chk("indicator cycles", 10, 30, cnt[0]);
        chk("tone toggles", 10, 16, cnt[1]);
        chk("tone end", 30, 52, cnt[2]);
        chk("session after read", 0, 0, cnt[3]);
        chk("beeper idle", 0, 0, {31'h0, beeper_out});
        fork host_u.press(4); join_none
        measure(60);
        chk("released session", 3, 5, cnt[3]);
        chk("no indication", 0, 0, cnt[0] + cnt[1]);
        $display("test level mode done");
        // Engine reset line: short low ignored, long low flagged
        fork host_u.hold_reset(15); join_none
        measure(40);
        chk("short reset flag", 0, 0, cnt[4]);
        fork host_u.hold_reset(40); join_none
        measure(80);
        chk("long reset flag", 16, 22, cnt[4]);
        $display("test engine reset done");
        // Pulse mode, indicator and tones off: timeout, then silent read
        apb(1'b1, 12'h000, 32'h1);
        fork host_u.press(500); join_none
        measure(1200);
        chk("pulse session", 980, 1020, cnt[3]);
        fork host_u.press(5); join_none
        repeat (10) @(posedge sys_clk);
        decode_done <= 1'b1;
        @(posedge sys_clk);
        decode_done <= 1'b0;
        measure(120);
        chk("silent read", 0, 0, cnt[0] + cnt[1] + cnt[3]);
        $display("test pulse mode done");
        test_done();
    end
endmodule // stfc_scan_trigger_feedback_ctrl_tb_top
